// file: cpx_pkg.sv
// cpx_pkg: constants and types for the panel fault-led and export framer
// assumes a 50 MHz pclk and a same-clock CAN controller on both frame ports
package cpx_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] CPX_CTRL_OFS   = 12'h000;
  localparam logic [11:0] CPX_STATUS_OFS = 12'h004;
  localparam logic [11:0] CPX_TXID_OFS   = 12'h008;
  localparam logic [11:0] CPX_RXID_OFS   = 12'h018;
  localparam logic [11:0] CPX_EXPID_OFS  = 12'h028;
  localparam logic [11:0] CPX_EXPCTL_OFS = 12'h048;
  localparam logic [11:0] CPX_SLOT_OFS   = 12'h100;
  localparam logic [11:0] CPX_SLOT_END   = 12'h1fc;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int          CPX_CTRL_TERM_BIT = 0;
  localparam int          CPX_CTRL_LEG_BIT  = 1;
  localparam int          CPX_CTRL_BRP_LSB  = 16;
  localparam int          CPX_BRP_W         = 10;
  localparam int          CPX_ID_EXT_BIT    = 31;
  localparam int          CPX_ID_EN_BIT     = 30;
  localparam int          CPX_EXP_CHG_BIT   = 0;
  localparam int          CPX_EXP_PER_BIT   = 1;
  localparam int          CPX_EXP_PER_LSB   = 16;
  localparam logic [28:0] CPX_STD_ID_MAX    = 29'h00007ff;
  localparam logic [7:0]  CPX_FAULT_TAG     = 8'h0a;
  localparam int          CPX_NUM_RED       = 20;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CPX_CLK_HZ      = 50_000_000;
  localparam int          CPX_RATE_MIN    = 10_000;
  localparam int          CPX_RATE_MAX    = 1_000_000;
  localparam int          CPX_TQ_PER_BIT  = 10;
  localparam logic [9:0]  CPX_BRP_MIN     = 10'(CPX_CLK_HZ / (CPX_RATE_MAX * CPX_TQ_PER_BIT));
  localparam logic [9:0]  CPX_BRP_MAX     = 10'(CPX_CLK_HZ / (CPX_RATE_MIN * CPX_TQ_PER_BIT));
  localparam int          CPX_TICK_MS     = 1;
  localparam int          CPX_MS_CYCLES   = CPX_CLK_HZ / 1000 * CPX_TICK_MS;
  localparam logic [31:0] CPX_CTRL_RST    = {6'h00, CPX_BRP_MAX, 16'h0000};

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CPX_FMT_NONE  = 4'h0,
    CPX_FMT_SWLO  = 4'h1,
    CPX_FMT_SWHI  = 4'h2,
    CPX_FMT_GRLO  = 4'h3,
    CPX_FMT_GRHI  = 4'h4,
    CPX_FMT_CONST = 4'h5,
    CPX_FMT_AN8   = 4'h6,
    CPX_FMT_ANLO  = 4'h7,
    CPX_FMT_ANHI  = 4'h8
  } cpx_fmt_t;

  typedef enum logic [1:0] {
    CPX_FR_IDLE  = 2'b00,
    CPX_FR_BUILD = 2'b01,
    CPX_FR_SEND  = 2'b10
  } cpx_fr_t;

  typedef struct packed {
    logic        ext;
    logic        en;
    logic        pad;
    logic [28:0] id;
  } cpx_id_t;

  typedef struct packed {
    logic        ext;
    logic [28:0] id;
    logic [63:0] data;
  } cpx_frame_t;

  typedef struct packed {
    logic [15:0] period;
    logic        per;
    logic        chg;
  } cpx_expctl_t;

endpackage : cpx_pkg

// file: cpx_cfg_mem.sv
// cpx_cfg_mem: export slot configuration store, one write and one read port
// assumes the caller keeps addresses in range; read data appear one cycle late
`timescale 1ns/100ps
`default_nettype none
module cpx_cfg_mem #(
  parameter int W     = 16,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output var  logic [W-1:0]  rdata
);

  logic [W-1:0] mem [DEPTH];

  if (DEPTH > (1 << AW)) begin : g_chk
    $error("cpx_cfg_mem depth exceeds address range");
  end

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // contents are not reset; software loads every slot it enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule : cpx_cfg_mem
`default_nettype wire

// file: cpx_framer.sv
// cpx_framer: fault-led decode of legacy frames and export frame builder
// assumes a CAN controller on pclk that delivers rx frames and takes tx frames
//
// Contract
// - act on legacy fault frame only when payload byte 0 equals ten
// - red leds follow bits of bytes 7, 6, 5: one lights, zero darkens
// - leds 1-8 byte 7, 9-16 byte 6, 17-20 byte 5 bits 0-3
// - bit rate settable from ten kilobit to one megabit per second
// - termination control follows the termination setting
// - legacy setting adds standard frames alongside advanced ones
// - primary, secondary advanced and two legacy transmit identifiers
// - separate receive identifiers, independent of transmit ones
// - identifiers are 11 or 29 bit; 11 bit limited to 7ff
// - eight export identifiers, each with its own 29 bit flag
// - export sent on switch change, periodically, or both
// - switch slot carries low or high byte of switch value
// - group slot carries low or high byte of group value
// - byte order follows the slot layout, none imposed
// - constant slot sends a fixed configured byte
// - analogue is ten bit in two bytes or eight bit in one
// - analogue slot source is one of three sensors or supply
`timescale 1ns/100ps
`default_nettype none
module cpx_framer
  import cpx_pkg::*;
#(
  parameter int NSW       = 20,
  parameter int NGRP      = 20,
  parameter int MS_CYCLES = CPX_MS_CYCLES
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  input  wire logic                  rx_valid,
  input  wire cpx_frame_t            rx_frame,
  output var  logic                  tx_valid,
  input  wire logic                  tx_ready,
  output var  cpx_frame_t            tx_frame,
  input  wire logic [NSW-1:0]        sw_on,
  input  wire logic [NSW-1:0][15:0]  sw_val,
  input  wire logic [NGRP-1:0][15:0] grp_val,
  input  wire logic [3:0][9:0]       an_val,
  output var  logic [19:0]           red_led,
  output var  logic                  term_en,
  output var  logic                  can_tq_en,
  output var  logic                  adv_cmd_valid
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (MS_CYCLES < 1 || MS_CYCLES > 65535) begin : g_chk_ms
    $error("cpx_framer MS_CYCLES out of range");
  end
  if (NSW < CPX_NUM_RED || NSW > 256 || NGRP < 1 || NGRP > 256) begin : g_chk_sw
    $error("cpx_framer switch or group count unsupported");
  end

  typedef struct packed {
    logic                  term;
    logic                  leg;
    logic [9:0]            brp;
    cpx_id_t [3:0]         txid;
    cpx_id_t [3:0]         rxid;
    cpx_id_t [7:0]         expid;
    cpx_expctl_t [7:0]     expctl;
    logic [7:0][15:0]      per_cnt;
    logic [15:0]           ms_cnt;
    logic                  ms_tick;
    logic [9:0]            tq_cnt;
    logic                  tq_en;
    logic [19:0]           red;
    logic [NSW-1:0]        sw_prev;
    logic [11:0]           pend;
    cpx_fr_t               fr;
    logic [2:0]            cur;
    logic [3:0]            slot;
    logic                  rpend;
    logic [2:0]            rslot;
    cpx_frame_t            frame;
    logic                  txv;
    logic [31:0]           prdata;
    logic                  mwait;
    logic                  adv_hit;
  } cpx_state_t;

  cpx_state_t s_ff;
  cpx_state_t nxt_s;

  logic        apb_setup;
  logic        apb_access;
  logic        in_mem;
  logic        mapped;
  logic        apb_mrd;
  logic        apb_we;
  logic        mem_re;
  logic [5:0]  mem_raddr;
  logic [15:0] mem_rdata;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // clamps a standard id to 11 bits on write so no frame can carry more
  function automatic cpx_id_t id_load(input logic [31:0] d);
    cpx_id_t r;
    r.ext = d[CPX_ID_EXT_BIT];
    r.en  = d[CPX_ID_EN_BIT];
    r.pad = 1'b0;
    r.id  = d[28:0];
    if (!r.ext && r.id > CPX_STD_ID_MAX) begin
      r.id = CPX_STD_ID_MAX;
    end
    return r;
  endfunction : id_load

  function automatic logic id_match(input cpx_id_t r, input cpx_frame_t f);
    return r.en && (r.ext == f.ext) && (r.id == f.id);
  endfunction : id_match

  function automatic logic [7:0] slot_byte(input logic [15:0] cfg);
    logic [7:0] sel;
    logic [9:0] an;
    sel = cfg[7:0];
    an  = an_val[sel[1:0]];
    slot_byte = 8'h00;
    unique case (cfg[15:12])
      CPX_FMT_SWLO:  slot_byte = (32'(sel) < NSW) ? sw_val[sel][7:0] : 8'h00;
      CPX_FMT_SWHI:  slot_byte = (32'(sel) < NSW) ? sw_val[sel][15:8] : 8'h00;
      CPX_FMT_GRLO:  slot_byte = (32'(sel) < NGRP) ? grp_val[sel][7:0] : 8'h00;
      CPX_FMT_GRHI:  slot_byte = (32'(sel) < NGRP) ? grp_val[sel][15:8] : 8'h00;
      CPX_FMT_CONST: slot_byte = sel;
      // analogue from sensor 0..2 or supply 3
      CPX_FMT_AN8:   slot_byte = an[9:2];
      CPX_FMT_ANLO:  slot_byte = an[7:0];
      CPX_FMT_ANHI:  slot_byte = {6'h00, an[9:8]};
      default:       slot_byte = 8'h00;
    endcase
  endfunction : slot_byte

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign apb_setup  = psel && !penable;
  assign apb_access = psel && penable;
  assign in_mem     = (paddr >= CPX_SLOT_OFS) && (paddr <= CPX_SLOT_END);
  assign mapped     = in_mem || (paddr < CPX_SLOT_OFS && paddr < 12'h068 && paddr[1:0] == 2'b00);
  assign apb_mrd    = apb_setup && !pwrite && in_mem;
  assign pready     = apb_access && (!in_mem || pwrite || s_ff.mwait);
  assign pslverr    = apb_access && pready && !mapped;
  assign apb_we     = apb_access && pready && pwrite && mapped;
  // bus reads take the store first; the builder just waits a cycle
  assign mem_re     = apb_mrd || (s_ff.fr == CPX_FR_BUILD && !s_ff.slot[3]);
  assign mem_raddr  = apb_mrd ? paddr[7:2] : {s_ff.cur, s_ff.slot[2:0]};

  cpx_cfg_mem #(.W(16), .DEPTH(64), .AW(6)) u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (apb_we && in_mem),
    .waddr   (paddr[7:2]),
    .wdata   (pwdata[15:0]),
    .re      (mem_re),
    .raddr   (mem_raddr),
    .rdata   (mem_rdata)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [11:0] set;
    logic [11:0] clr;
    logic [3:0]  k;
    logic        found;
    logic [31:0] rd;
    nxt_s = s_ff;
    set   = '0;
    clr   = '0;
    k     = '0;
    found = 1'b0;
    rd    = 32'h0000_0000;

    // register reads are captured in setup, slot reads one cycle into access
    if (apb_setup && !pwrite) begin
      if (paddr == CPX_CTRL_OFS) begin
        rd = {6'h00, s_ff.brp, 14'h0000, s_ff.leg, s_ff.term};
      end else if (paddr == CPX_STATUS_OFS) begin
        rd = {12'h000, s_ff.red};
      end else if (paddr >= CPX_TXID_OFS && paddr < CPX_RXID_OFS) begin
        rd = s_ff.txid[2'(paddr[11:2] - CPX_TXID_OFS[11:2])];
      end else if (paddr >= CPX_RXID_OFS && paddr < CPX_EXPID_OFS) begin
        rd = s_ff.rxid[2'(paddr[11:2] - CPX_RXID_OFS[11:2])];
      end else if (paddr >= CPX_EXPID_OFS && paddr < CPX_EXPCTL_OFS) begin
        rd = s_ff.expid[3'(paddr[11:2] - CPX_EXPID_OFS[11:2])];
      end else if (paddr >= CPX_EXPCTL_OFS && paddr < 12'h068) begin
        rd = {s_ff.expctl[3'(paddr[11:2] - CPX_EXPCTL_OFS[11:2])].period, 14'h0000,
              s_ff.expctl[3'(paddr[11:2] - CPX_EXPCTL_OFS[11:2])].per,
              s_ff.expctl[3'(paddr[11:2] - CPX_EXPCTL_OFS[11:2])].chg};
      end
      nxt_s.prdata = rd;
    end
    nxt_s.mwait = apb_access && in_mem && !pwrite && !s_ff.mwait;
    if (apb_access && in_mem && !pwrite && !s_ff.mwait) begin
      nxt_s.prdata = {16'h0000, mem_rdata};
    end

    if (apb_we) begin
      if (paddr == CPX_CTRL_OFS) begin
        nxt_s.term = pwdata[CPX_CTRL_TERM_BIT];
        nxt_s.leg  = pwdata[CPX_CTRL_LEG_BIT];
        nxt_s.brp  = pwdata[CPX_CTRL_BRP_LSB +: CPX_BRP_W];
        // prescaler held inside the 10 kbit to 1 Mbit span
        if (pwdata[CPX_CTRL_BRP_LSB +: CPX_BRP_W] < CPX_BRP_MIN) begin
          nxt_s.brp = CPX_BRP_MIN;
        end else if (pwdata[CPX_CTRL_BRP_LSB +: CPX_BRP_W] > CPX_BRP_MAX) begin
          nxt_s.brp = CPX_BRP_MAX;
        end
      end else if (paddr >= CPX_TXID_OFS && paddr < CPX_RXID_OFS) begin
        nxt_s.txid[2'(paddr[11:2] - CPX_TXID_OFS[11:2])] = id_load(pwdata);
      end else if (paddr >= CPX_RXID_OFS && paddr < CPX_EXPID_OFS) begin
        // receive set kept apart from transmit set
        nxt_s.rxid[2'(paddr[11:2] - CPX_RXID_OFS[11:2])] = id_load(pwdata);
      end else if (paddr >= CPX_EXPID_OFS && paddr < CPX_EXPCTL_OFS) begin
        // each export id carries its own extended flag
        nxt_s.expid[3'(paddr[11:2] - CPX_EXPID_OFS[11:2])] = id_load(pwdata);
      end else if (paddr >= CPX_EXPCTL_OFS && paddr < 12'h068) begin
        nxt_s.expctl[3'(paddr[11:2] - CPX_EXPCTL_OFS[11:2])] =
          {pwdata[CPX_EXP_PER_LSB +: 16], pwdata[CPX_EXP_PER_BIT], pwdata[CPX_EXP_CHG_BIT]};
      end
    end

    nxt_s.tq_en = 1'b0;
    if (s_ff.tq_cnt >= s_ff.brp - 10'h001) begin
      nxt_s.tq_cnt = '0;
      nxt_s.tq_en  = 1'b1;
    end else begin
      nxt_s.tq_cnt = s_ff.tq_cnt + 10'h001;
    end

    nxt_s.ms_tick = 1'b0;
    if (32'(s_ff.ms_cnt) >= MS_CYCLES - 1) begin
      nxt_s.ms_cnt  = '0;
      nxt_s.ms_tick = 1'b1;
    end else begin
      nxt_s.ms_cnt = s_ff.ms_cnt + 16'h0001;
    end

    // only configured ids are looked at, leds otherwise hold
    nxt_s.adv_hit = rx_valid && (id_match(s_ff.rxid[0], rx_frame) || id_match(s_ff.rxid[1], rx_frame));
    if (rx_valid && (id_match(s_ff.rxid[2], rx_frame) || id_match(s_ff.rxid[3], rx_frame))) begin
      // tag byte gates the fault decode
      if (rx_frame.data[7:0] == CPX_FAULT_TAG) begin
        // bytes 7, 6, 5 onto leds 1-8, 9-16, 17-20
        nxt_s.red = {rx_frame.data[43:40], rx_frame.data[55:48], rx_frame.data[63:56]};
      end
    end

    nxt_s.sw_prev = sw_on;
    if (sw_on != s_ff.sw_prev) begin
      // advanced primary and secondary status frames
      set[0] = s_ff.txid[0].en;
      set[1] = s_ff.txid[1].en;
      // legacy frames added, never instead of advanced ones
      set[2] = s_ff.leg && s_ff.txid[2].en;
      set[3] = s_ff.leg && s_ff.txid[3].en;
      for (int i = 0; i < 8; i++) begin
        set[4+i] = s_ff.expid[i].en && s_ff.expctl[i].chg;
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (s_ff.ms_tick && s_ff.expctl[i].per && s_ff.expctl[i].period != 16'h0000) begin
        if (s_ff.per_cnt[i] + 16'h0001 >= s_ff.expctl[i].period) begin
          nxt_s.per_cnt[i] = '0;
          set[4+i]         = set[4+i] | s_ff.expid[i].en;
        end else begin
          nxt_s.per_cnt[i] = s_ff.per_cnt[i] + 16'h0001;
        end
      end
    end

    // ----------------------------------------------------------------
    // frame builder
    // ----------------------------------------------------------------
    unique case (s_ff.fr)
      CPX_FR_IDLE: begin
        for (int i = 11; i >= 0; i--) begin
          if (s_ff.pend[i]) begin
            k     = 4'(i);
            found = 1'b1;
          end
        end
        if (found) begin
          clr[k] = 1'b1;
          if (k < 4'd4) begin
            nxt_s.frame.ext  = s_ff.txid[k[1:0]].ext;
            nxt_s.frame.id   = s_ff.txid[k[1:0]].id;
            nxt_s.frame.data = {sw_on[7:0], sw_on[15:8], 4'h0, sw_on[19:16], 40'h00_0000_0000};
            nxt_s.txv        = 1'b1;
            nxt_s.fr         = CPX_FR_SEND;
          end else begin
            nxt_s.cur        = 3'(k - 4'd4);
            nxt_s.frame.ext  = s_ff.expid[3'(k - 4'd4)].ext;
            nxt_s.frame.id   = s_ff.expid[3'(k - 4'd4)].id;
            nxt_s.frame.data = '0;
            nxt_s.slot       = '0;
            nxt_s.rpend      = 1'b0;
            nxt_s.fr         = CPX_FR_BUILD;
          end
        end
      end
      CPX_FR_BUILD: begin
        nxt_s.rpend = !apb_mrd && !s_ff.slot[3];
        if (!apb_mrd && !s_ff.slot[3]) begin
          nxt_s.rslot = s_ff.slot[2:0];
          nxt_s.slot  = s_ff.slot + 4'h1;
        end
        if (s_ff.rpend) begin
          // each slot lands at its own byte index, no reordering
          nxt_s.frame.data[8*s_ff.rslot +: 8] = slot_byte(mem_rdata);
          if (s_ff.rslot == 3'd7) begin
            nxt_s.txv = 1'b1;
            nxt_s.fr  = CPX_FR_SEND;
          end
        end
      end
      CPX_FR_SEND: begin
        if (tx_ready) begin
          nxt_s.txv = 1'b0;
          nxt_s.fr  = CPX_FR_IDLE;
        end
      end
      default: begin
        nxt_s.txv = 1'b0;
        nxt_s.fr  = CPX_FR_IDLE;
      end
    endcase
    // a trigger in the cycle its request is taken stays pending
    nxt_s.pend = (s_ff.pend & ~clr) | set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff      <= '0;
      s_ff.brp  <= CPX_BRP_MAX;
      s_ff.fr   <= CPX_FR_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata        = s_ff.prdata;
  assign tx_valid      = s_ff.txv;
  assign tx_frame      = s_ff.frame;
  assign red_led       = s_ff.red;
  assign term_en       = s_ff.term;
  assign can_tq_en     = s_ff.tq_en;
  assign adv_cmd_valid = s_ff.adv_hit;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic leg_rx;
  assign leg_rx = rx_valid && (id_match(s_ff.rxid[2], rx_frame) || id_match(s_ff.rxid[3], rx_frame));

  sequence fault_frame_s;
    leg_rx && rx_frame.data[7:0] == CPX_FAULT_TAG;
  endsequence

  sequence mem_read_s;
    apb_mrd ##1 (apb_access && !pready);
  endsequence

  red_tag_gate_a: assert property ((rx_valid && !(leg_rx && rx_frame.data[7:0] == CPX_FAULT_TAG))
    |=> red_led == $past(red_led)) else $error("red leds changed without a tagged frame");
  red_map_a: assert property (fault_frame_s |=> red_led == {$past(rx_frame.data[43:40]),
    $past(rx_frame.data[55:48]), $past(rx_frame.data[63:56])}) else $error("red led map wrong");
  term_follow_a: assert property ((apb_we && paddr == CPX_CTRL_OFS)
    |=> term_en == $past(pwdata[CPX_CTRL_TERM_BIT])) else $error("termination not following write");
  tq_space_a: assert property ($rose(can_tq_en) |=> !can_tq_en [*4]) else $error("quantum faster than 1 Mbit");
  brp_range_a: assert property (s_ff.brp >= CPX_BRP_MIN && s_ff.brp <= CPX_BRP_MAX)
    else $error("prescaler outside bit rate span");
  std_id_a: assert property ((tx_valid && !tx_frame.ext) |-> tx_frame.id <= CPX_STD_ID_MAX)
    else $error("standard id above 7ff");
  legacy_gate_a: assert property ((s_ff.fr == CPX_FR_IDLE && nxt_s.fr == CPX_FR_SEND && s_ff.pend[1:0] == 2'b00)
    |-> s_ff.leg) else $error("legacy frame sent while legacy off");
  slot_rd_a: assert property (mem_read_s |=> pready && prdata == {16'h0000, $past(mem_rdata)})
    else $error("slot read answer late or wrong");
  tx_hold_a: assert property ((tx_valid && !tx_ready) |=> tx_valid && $stable(tx_frame))
    else $error("tx frame dropped before taken");

endmodule : cpx_framer
`default_nettype wire

// file: cpx_can_model.sv
// cpx_can_model: CAN controller stand-in on the frame ports
// assumes pclk domain; slow makes tx_ready toggle
`timescale 1ns/100ps
`default_nettype none
module cpx_can_model
  import cpx_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire cpx_frame_t tx_frame,
  output var  logic       tx_ready,
  output var  logic       rx_valid,
  output var  cpx_frame_t rx_frame
);
  cpx_frame_t got[$];
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
  end
  // caller packs tag and fault bits
  task send(input cpx_frame_t f);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_frame <= f;
    @(posedge pclk);
    rx_valid <= 1'b0;
    // stale data must not look valid
    rx_frame <= ~f;
  endtask : send
  always @(posedge pclk) begin
    if (tx_valid && tx_ready)
      got.push_back(tx_frame);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule : cpx_can_model
`default_nettype wire

// file: testbench.sv
// testbench: cpx_framer over APB, CAN model on the frame ports
// assumes a 50-cycle millisecond
`timescale 1ns/100ps
`default_nettype none
module testbench
  import cpx_pkg::*;
;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic              slow, tx_valid, tx_ready, rx_valid, term_en, can_tq_en, adv_cmd_valid;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  cpx_frame_t        rx_frame, tx_frame;
  logic [19:0]       sw_on, red_led;
  logic [19:0][15:0] sw_val, grp_val;
  logic [3:0][9:0]   an_val;
  int                fail_count, total_checks, n;

  cpx_framer #(.MS_CYCLES(50)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx_valid, .rx_frame, .tx_valid, .tx_ready, .tx_frame, .sw_on,
    .sw_val, .grp_val, .an_val, .red_led, .term_en, .can_tq_en, .adv_cmd_valid);
  cpx_can_model can_u (.pclk, .slow, .tx_valid, .tx_frame, .tx_ready, .rx_valid, .rx_frame);

  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // idle cycle first so psel never changes twice in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (n = 0; pready !== 1'b1 && n < 20; n++)
      @(posedge pclk);
    if (n == 20)
      fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task t_ctrl;
    apb(0, CPX_CTRL_OFS, 0);
    chk(rd, CPX_CTRL_RST);
    chk({31'h0, term_en}, 0);
    apb(1, CPX_CTRL_OFS, 32'h00010000);
    apb(0, CPX_CTRL_OFS, 0);
    chk(rd, {6'h0, CPX_BRP_MIN, 16'h0});
    apb(1, CPX_CTRL_OFS, {6'h0, CPX_BRP_MIN, 16'h0003});
    repeat (10) @(posedge pclk);
    n = 0;
    repeat (50) @(posedge pclk) n += int'(can_tq_en);
    chk(n, 10);
    chk({31'h0, term_en}, 1);
  endtask : t_ctrl
  task t_fault;
    apb(1, CPX_RXID_OFS + 12'h8, 32'h40000123);
    can_u.send({1'b0, 29'h123, 64'ha53cf9000000000a});
    @(posedge pclk);
    chk(red_led, 20'h93ca5);
    apb(1, CPX_RXID_OFS, 32'h40000321);
    can_u.send({1'b0, 29'h321, 64'h0a});
    @(posedge pclk);
    chk({31'h0, adv_cmd_valid}, 1);
    can_u.send({1'b0, 29'h123, 64'h0b});
    can_u.send({1'b0, 29'h124, 64'h0a});
    apb(0, CPX_STATUS_OFS, 0);
    chk(rd, 32'h93ca5);
    can_u.send({1'b0, 29'h123, 64'h0a});
    @(posedge pclk);
    chk(red_led, 0);
  endtask : t_fault
  task t_ids;
    apb(1, CPX_TXID_OFS + 12'hc, 32'h40000fff);
    apb(0, CPX_TXID_OFS + 12'hc, 0);
    chk(rd, 32'h400007ff);
    apb(1, CPX_EXPID_OFS + 12'h4, 32'hc0abcdef);
    apb(0, CPX_EXPID_OFS + 12'h4, 0);
    chk(rd, 32'hc0abcdef);
    apb(0, 12'h0a0, 0);
    chk({31'h0, err}, 1);
  endtask : t_ids
  task t_tx;
    apb(1, CPX_TXID_OFS, 32'h40000100);
    apb(1, CPX_TXID_OFS + 12'h8, 32'h40000200);
    apb(1, CPX_EXPID_OFS, 32'h40000500);
    apb(1, CPX_EXPCTL_OFS, 32'h1);
    apb(1, CPX_SLOT_OFS, 32'h505a);
    apb(1, CPX_SLOT_OFS + 12'h4, 32'h1002);
    apb(1, CPX_SLOT_OFS + 12'h8, 32'h2002);
    for (int i = 3; i < 8; i++)
      apb(1, CPX_SLOT_OFS + 12'(4 * i), 0);
    apb(0, CPX_SLOT_OFS + 12'h4, 0);
    chk(rd, 32'h00001002);
    slow <= 1'b1;
    sw_on <= 20'h5a3c1;
    for (n = 0; can_u.got.size() < 4 && n < 300; n++)
      @(posedge pclk);
    chk(32'(can_u.got.size()), 4);
    chk(can_u.got[0].id, 29'h100);
    chk(can_u.got[1].id, 29'h200);
    chk(can_u.got[1].data[63:40], 24'hc1a305);
    chk(can_u.got[2].id, 29'h7ff);
    chk(can_u.got[3].id, 29'h500);
    chk(can_u.got[3].data[23:0], 24'h12345a);
  endtask : t_tx
  // periodic-only export of analogue and group bytes
  task t_per;
    logic [7:0][15:0] cfg;
    cfg = {48'h0, 16'h4004, 16'h3004, 16'h7003, 16'h8003, 16'h6001};
    an_val[1] <= 10'h2c7;
    an_val[3] <= 10'h1a4;
    grp_val[4] <= 16'hbeef;
    for (int i = 0; i < 8; i++)
      apb(1, CPX_SLOT_OFS + 12'h020 + 12'(4 * i), {16'h0, cfg[i]});
    apb(1, CPX_EXPID_OFS + 12'h4, 32'h40000501);
    apb(1, CPX_EXPCTL_OFS + 12'h4, 32'h00020002);
    for (n = 0; can_u.got.size() < 5 && n < 400; n++)
      @(posedge pclk);
    chk(32'(can_u.got.size()), 5);
    chk(can_u.got[4].id, 29'h501);
    chk(can_u.got[4].data[31:0], 32'hefa401b1);
    chk(can_u.got[4].data[63:32], 32'h000000be);
  endtask : t_per
  task end_sim;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, slow, paddr, pwdata, sw_on} = '0;
    sw_val = {20{16'h1234}};
    grp_val = '0;
    an_val = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_ctrl();
    t_fault();
    t_ids();
    t_tx();
    t_per();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    end_sim();
  end
endmodule : testbench
`default_nettype wire
